// *** dv/synth_mode_bias_regs_assertions.sv ***
// port-level checker for the modes, bias and calibration bank
module synth_mode_bias_regs_assertions (
  input wire logic        clock, srst, wr_stb, rd_stb, chip_enable, synth_locked,
  input wire logic        subsys_active, ext_buf_en, syn_buf_en, ext_input_en,
  input wire logic        main_tone_neg_pin, main_tone_pos_pin, second_tone_neg_pin,
  input wire logic        second_tone_pos_pin, pump_out_first, pump_out_second,
  input wire logic        cal_programmed,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata, rdata,
  input wire logic [1:0]  ext_input_bias
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence modes_wr;
    wr_stb && addr == synth_mode_pkg::MODES_IDX;
  endsequence
  sequence unlocked_wr;
    (!synth_locked)[*3] ##0 modes_wr ##0 wdata[7];
  endsequence
  reset_vals_a: assert property ($past(srst) |-> ext_input_bias == 2'b00 && !cal_programmed)
    else $error("bias or cal not at reset value");
  ce_gate_a: assert property (subsys_active |-> $past(chip_enable, 2))
    else $error("active without chip enable");
  buf_gate_a: assert property ((ext_buf_en || syn_buf_en || ext_input_en) |-> subsys_active)
    else $error("buffer on while inactive");
  tone_gate_a: assert property ((main_tone_neg_pin || second_tone_neg_pin) |-> subsys_active)
    else $error("tone on while inactive");
  prelock_mute_a: assert property (unlocked_wr |=> !main_tone_neg_pin && !second_tone_neg_pin)
    else $error("tone not muted before lock");
  tone1_mode_a: assert property (modes_wr |=> main_tone_pos_pin == (main_tone_neg_pin && !$past(wdata[8])))
    else $error("first tone pin mode wrong");
  tone2_mode_a: assert property (modes_wr |=> second_tone_pos_pin == (second_tone_neg_pin && !$past(wdata[9])))
    else $error("second tone pin mode wrong");
  pump_sel_a: assert property (modes_wr |=> pump_out_second == (subsys_active && $past(wdata[11]))
    && pump_out_first == (subsys_active && !$past(wdata[11])))
    else $error("charge pump route wrong");
  bias_wr_a: assert property (wr_stb && addr == synth_mode_pkg::BIAS_IDX |=> ext_input_bias == $past(wdata[20:19]))
    else $error("bias field not taken");
  cal_wr_a: assert property (wr_stb && addr == synth_mode_pkg::CAL_IDX
    |=> cal_programmed == ($past(wdata[23:0]) == synth_mode_pkg::CAL_REQUIRED))
    else $error("cal flag wrong");
  rdata_idle_a: assert property (!rd_stb |=> rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule
bind synth_mode_bias_regs synth_mode_bias_regs_assertions synth_mode_bias_regs_assertions_i (.*);

// *** dv/synth_mode_bias_regs_tb_top.sv ***
// self-checking bench for the modes, bias and calibration bank
module synth_mode_bias_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic chip_enable = 1'b0, synth_locked = 1'b0, cal_programmed;
  logic subsys_active, osc_active, ext_buf_en, syn_buf_en, ext_input_en, main_tone_neg_pin;
  logic main_tone_pos_pin, second_tone_neg_pin, second_tone_pos_pin, pump_out_first, pump_out_second;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0]  ext_input_bias;
  logic [10:0] pins;
  int          bad_count = 0, num_checks = 0;
  // mix of reserved bits, mute on and off, both pump routes
  logic [23:0] vecs [4] = '{24'h00_01ab, 24'hff_ffff, 24'h00_0000, 24'h00_0b5d};
  always #25 clock = ~clock;
  synth_mode_bias_regs synth_mode_bias_regs_i (.*);
  assign pins = {subsys_active, osc_active, ext_buf_en, syn_buf_en, ext_input_en, main_tone_neg_pin,
                 main_tone_pos_pin, second_tone_neg_pin, second_tone_pos_pin, pump_out_first, pump_out_second};
  function automatic logic [10:0] exp_pins(logic [23:0] m, logic ce, logic lk);
    logic a, t1, t2;
    a = m[0] & ce;
    t1 = a & m[4] & ~(m[7] & ~lk);
    t2 = a & m[5] & ~(m[7] & ~lk);
    return {a, a & m[1], a & m[2], a & m[3], a & m[6], t1, t1 & ~m[8], t2, t2 & ~m[9], a & ~m[11], a & m[11]};
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    wr_stb <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clock);
    rd_stb <= 1'b1; addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rd(synth_mode_pkg::MODES_IDX, 32'h0000_01ab);
    rd(synth_mode_pkg::BIAS_IDX, 32'h0000_54c1);
    rd(synth_mode_pkg::CAL_IDX, 32'h0000_0aaa);
    rd(8'h20, 32'h0000_0000);
    $display("reset values done");
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 4; v++) begin
        @(posedge clock);
        chip_enable <= c[0]; synth_locked <= c[1];
        wr(synth_mode_pkg::MODES_IDX, {8'h5a, vecs[v]});
        repeat (3) @(posedge clock);
        #1 chk("pins", {21'h0, exp_pins(vecs[v], c[0], c[1])}, {21'h0, pins});
        rd(synth_mode_pkg::MODES_IDX, {8'h00, vecs[v]});
      end
    end
    $display("mode decode done");
    wr(synth_mode_pkg::BIAS_IDX, 32'hff18_0000);
    rd(synth_mode_pkg::BIAS_IDX, 32'h0018_0000);
    chk("bias", 32'h3, {30'h0, ext_input_bias});
    wr(8'h20, 32'h0000_0000);
    wr(synth_mode_pkg::CAL_IDX, 32'h0000_0ab2);
    rd(synth_mode_pkg::CAL_IDX, 32'h0000_0ab2);
    chk("cal", 32'h1, {31'h0, cal_programmed});
    // status: active, locked, not muted, cal ok after last vector with both pins high
    rd(synth_mode_pkg::STATUS_IDX, 32'h0000_000b);
    wr(synth_mode_pkg::STATUS_IDX, 32'h0000_00f0);
    rd(synth_mode_pkg::STATUS_IDX, 32'h0000_000b);
    $display("bias and cal done");
    // second reset in mid-run must restore the documented values
    @(posedge clock);
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rd(synth_mode_pkg::MODES_IDX, 32'h0000_01ab);
    rd(synth_mode_pkg::BIAS_IDX, 32'h0000_54c1);
    rd(synth_mode_pkg::CAL_IDX, 32'h0000_0aaa);
    $display("mid-run reset done");
    complete_run;
  end
  // about 180 cycles expected; generous cut-off for a hang
  initial begin
    repeat (2000) @(posedge clock);
    bad_count++;
    complete_run;
  end
endmodule

// *** rtl/sync_two_ff.sv ***
// two-flop synchroniser for a single asynchronous level
module sync_two_ff (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;
  sync_state_t state_r;
  sync_state_t state_nxt;
  always_comb begin
    state_nxt.meta   = async_in;
    state_nxt.stable = state_r.meta;
    if (srst) begin
      state_nxt = '0;
    end
  end
  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end
  assign sync_out = state_r.stable;
endmodule

// *** rtl/synth_mode_bias_regs.sv ***
// modes, bias and calibration configuration registers with enable decode
// Summary of operation
// RULE1 - modes register resets to 1AB hex, all fields read and write
// RULE2 - bit 0 plus chip enable switches the whole oscillator subsystem on
// RULE3 - bit 2 enables external oscillator buffer to output stage
// RULE4 - bit 3 enables synthesizer buffer for internal oscillator
// RULE5 - bit 4 enables first tone output buffer
// RULE6 - bit 5 enables second tone output buffer
// RULE7 - bit 6 enables external oscillator input
// RULE8 - bit 7 mutes both tone buffers until lock is reported
// RULE9 - bit 8 set drives only first negative pin, else differential
// RULE10 - bit 9 set drives only second negative pin, else differential
// RULE11 - bit 11 routes charge pump to first output when 0, second when 1
// RULE12 - bias register resets to 54C1 hex; bits 20:19 form input bias
// RULE13 - software rewrites calibration register from AAA to AB2 hex
// RULE14 - modes reserved bits reset to zero and read back last write
module synth_mode_bias_regs (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [31:0]      rdata,
  input  wire logic        chip_enable,
  input  wire logic        synth_locked,
  output logic             subsys_active,
  output logic             osc_active,
  output logic             ext_buf_en,
  output logic             syn_buf_en,
  output logic             ext_input_en,
  output logic             main_tone_neg_pin,
  output logic             main_tone_pos_pin,
  output logic             second_tone_neg_pin,
  output logic             second_tone_pos_pin,
  output logic             pump_out_first,
  output logic             pump_out_second,
  output logic [1:0]       ext_input_bias,
  output logic             cal_programmed
);
  localparam int W = synth_mode_pkg::REG_W;

  typedef struct packed {
    logic [W-1:0]  modes;
    logic [W-1:0]  bias;
    logic [W-1:0]  cal;
    logic [31:0]   rdata;
  } bank_state_t;

  bank_state_t state_r;
  bank_state_t state_nxt;
  logic        chip_en_s;
  logic        locked_s;
  logic        active;
  logic        muted;
  logic [W-1:0] status_word;

  // pins from outside the clock domain
  sync_two_ff u_sync_ce (
    .clock    (clock),
    .srst     (srst),
    .async_in (chip_enable),
    .sync_out (chip_en_s)
  );
  sync_two_ff u_sync_lock (
    .clock    (clock),
    .srst     (srst),
    .async_in (synth_locked),
    .sync_out (locked_s)
  );

  function automatic logic mode_bit(input logic [W-1:0] m, input int idx);
    return m[idx];
  endfunction

  assign active = mode_bit(state_r.modes, synth_mode_pkg::MODE_MASTER_EN) & chip_en_s; // RULE2
  // with bit 7 set, mute holds until lock, so tone outputs carry no unsettled tone
  assign muted  = mode_bit(state_r.modes, synth_mode_pkg::MODE_PRELOCK_MUTE) & ~locked_s; // RULE8

  always_comb begin
    status_word = '0;
    status_word[synth_mode_pkg::STAT_ACTIVE] = active;
    status_word[synth_mode_pkg::STAT_LOCKED] = locked_s;
    status_word[synth_mode_pkg::STAT_MUTED]  = muted;
    status_word[synth_mode_pkg::STAT_CAL_OK] = (state_r.cal == synth_mode_pkg::CAL_REQUIRED);
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.rdata = '0;
    if (wr_stb) begin
      unique case (addr)
        synth_mode_pkg::MODES_IDX: state_nxt.modes = wdata[W-1:0]; // RULE1 RULE14
        synth_mode_pkg::BIAS_IDX:  state_nxt.bias  = wdata[W-1:0]; // RULE12
        synth_mode_pkg::CAL_IDX:   state_nxt.cal   = wdata[W-1:0]; // RULE13
        default: ;
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        synth_mode_pkg::MODES_IDX:  state_nxt.rdata = {8'h00, state_r.modes};
        synth_mode_pkg::BIAS_IDX:   state_nxt.rdata = {8'h00, state_r.bias};
        synth_mode_pkg::CAL_IDX:    state_nxt.rdata = {8'h00, state_r.cal};
        synth_mode_pkg::STATUS_IDX: state_nxt.rdata = {8'h00, status_word};
        default:                    state_nxt.rdata = '0;
      endcase
    end
    if (srst) begin
      state_nxt.modes = synth_mode_pkg::MODES_RST; // RULE1 RULE14
      state_nxt.bias  = synth_mode_pkg::BIAS_RST; // RULE12
      state_nxt.cal   = synth_mode_pkg::CAL_RST;
      state_nxt.rdata = '0;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  assign rdata         = state_r.rdata;
  assign subsys_active = active;
  assign osc_active    = active & mode_bit(state_r.modes, synth_mode_pkg::MODE_OSC_EN);
  assign ext_buf_en    = active & mode_bit(state_r.modes, synth_mode_pkg::MODE_EXT_BUF_EN); // RULE3
  assign syn_buf_en    = active & mode_bit(state_r.modes, synth_mode_pkg::MODE_SYN_BUF_EN); // RULE4
  assign ext_input_en  = active & mode_bit(state_r.modes, synth_mode_pkg::MODE_EXT_IN_EN); // RULE7
  assign pump_out_first  = active & ~mode_bit(state_r.modes, synth_mode_pkg::MODE_PUMP_SEL); // RULE11
  assign pump_out_second = active & mode_bit(state_r.modes, synth_mode_pkg::MODE_PUMP_SEL); // RULE11
  assign ext_input_bias  = state_r.bias[synth_mode_pkg::BIAS_LSB +: synth_mode_pkg::BIAS_W]; // RULE12
  assign cal_programmed  = status_word[synth_mode_pkg::STAT_CAL_OK];

  tone_pin_ctrl u_tone1 (
    .buf_en       (active & mode_bit(state_r.modes, synth_mode_pkg::MODE_TONE1_EN)), // RULE5
    .single_ended (mode_bit(state_r.modes, synth_mode_pkg::MODE_TONE1_SE)), // RULE9
    .muted        (muted),
    .neg_en       (main_tone_neg_pin),
    .pos_en       (main_tone_pos_pin)
  );
  tone_pin_ctrl u_tone2 (
    .buf_en       (active & mode_bit(state_r.modes, synth_mode_pkg::MODE_TONE2_EN)), // RULE6
    .single_ended (mode_bit(state_r.modes, synth_mode_pkg::MODE_TONE2_SE)), // RULE10
    .muted        (muted),
    .neg_en       (second_tone_neg_pin),
    .pos_en       (second_tone_pos_pin)
  );
endmodule

// *** rtl/synth_mode_pkg.sv ***
// constants for the modes, bias and calibration register bank
package synth_mode_pkg;
  localparam int REG_W    = 24;
  localparam int ADDR_W   = 8;
  // offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] MODES_IDX = 8'h17;
  localparam logic [ADDR_W-1:0] BIAS_IDX  = 8'h18;
  localparam logic [ADDR_W-1:0] CAL_IDX   = 8'h19;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 8'h1a;
  localparam logic [REG_W-1:0] MODES_RST = 24'h00_01ab;
  localparam logic [REG_W-1:0] BIAS_RST  = 24'h00_54c1;
  localparam logic [REG_W-1:0] CAL_RST   = 24'h00_0aaa;
  localparam logic [REG_W-1:0] CAL_REQUIRED = 24'h00_0ab2;
  localparam int MODE_MASTER_EN   = 0;
  localparam int MODE_OSC_EN      = 1;
  localparam int MODE_EXT_BUF_EN  = 2;
  localparam int MODE_SYN_BUF_EN  = 3;
  localparam int MODE_TONE1_EN    = 4;
  localparam int MODE_TONE2_EN    = 5;
  localparam int MODE_EXT_IN_EN   = 6;
  localparam int MODE_PRELOCK_MUTE = 7;
  localparam int MODE_TONE1_SE    = 8;
  localparam int MODE_TONE2_SE    = 9;
  localparam int MODE_PUMP_SEL    = 11;
  localparam int BIAS_LSB         = 19;
  localparam int BIAS_W           = 2;
  // status word bit positions
  localparam int STAT_ACTIVE   = 0;
  localparam int STAT_LOCKED   = 1;
  localparam int STAT_MUTED    = 2;
  localparam int STAT_CAL_OK   = 3;
endpackage

// *** rtl/tone_pin_ctrl.sv ***
// enable decode for one local-oscillator output pin pair
module tone_pin_ctrl (
  input  wire logic buf_en,
  input  wire logic single_ended,
  input  wire logic muted,
  output logic      neg_en,
  output logic      pos_en
);
  // negative pin always carries the single-ended signal
  assign neg_en = buf_en & ~muted;
  assign pos_en = buf_en & ~muted & ~single_ended;
endmodule
